// *** include/aod_map.vh ***
`ifndef AOD_MAP_VH
`define AOD_MAP_VH

// register byte addresses
`define AOD_ADDR_CTRL 8'h00
`define AOD_ADDR_THRESH 8'h04
`define AOD_ADDR_STATUS 8'h08
`define AOD_ADDR_MASK 8'h0C
`define AOD_ADDR_STATE 8'h10

// control register fields
`define AOD_CTRL_EN 0
`define AOD_CTRL_HOLD_LO 1
`define AOD_CTRL_HOLD_HI 3
`define AOD_CTRL_BGCAL 4
`define AOD_CTRL_FGSTART 5

// status, mask and state register fields
`define AOD_STAT_OVR_LO 0
`define AOD_STAT_OVR_HI 3
`define AOD_STAT_FGDONE 4
`define AOD_STATE_BUSY 4
`define AOD_STATE_CORE_LO 5
`define AOD_STATE_CORE_HI 7

// reset values
`define AOD_CTRL_RST 8'h00
`define AOD_THRESH_RST 8'hE4
`define AOD_MASK_RST 8'h00
`define AOD_STATUS_RST 8'h00
`define AOD_RDATA_RST 8'h00

// sample format and magnitude
`define AOD_MIN_CODE 12'h800
`define AOD_MAX_MAG 11'h7FF
`define AOD_ONE_CODE 12'h001

// hold length base, shifted left by the hold select code
`define AOD_HOLD_BASE 11'h008
`define AOD_HOLD_ZERO 11'h000
`define AOD_HOLD_ONE 11'h001

// calibration sequencer
`define AOD_CAL_CYCLES 16'h0040
`define AOD_CAL_CNT_ZERO 16'h0000
`define AOD_CAL_CNT_ONE 16'h0001
`define AOD_CORE_ZERO 3'h0
`define AOD_CORE_ONE 3'h1

`endif

// *** hw/aod_chan.v ***
`timescale 1ns/1ps
`include "aod_map.vh"

module aod_chan #(
  parameter SW = 12,
  parameter MW = 11,
  parameter CW = 11
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // sample path
  input wire [SW-1:0] sample,
  input wire sample_valid,
  // shared settings
  input wire detect_enable,
  input wire [7:0] threshold,
  input wire [2:0] hold_select,
  // results
  output reg overrange_out,
  output reg event_pulse
);

  wire is_neg;
  wire [SW-1:0] negated;
  wire [MW-1:0] magnitude;
  wire [7:0] upper_mag;
  wire hit;
  wire [CW-1:0] hold_len;
  reg [CW-1:0] cnt_reg;

  // two's complement sign and magnitude, most negative code saturates
  assign is_neg = sample[SW-1];
  assign negated = ~sample + `AOD_ONE_CODE;
  assign magnitude = (sample == `AOD_MIN_CODE) ? `AOD_MAX_MAG :
                     (is_neg ? negated[MW-1:0] : sample[MW-1:0]);
  assign upper_mag = magnitude[MW-1:MW-8];
  // compare against the common threshold while enabled
  assign hit = detect_enable & sample_valid & (upper_mag >= threshold);
  assign hold_len = `AOD_HOLD_BASE << hold_select;

  // hold counter, restarted by every new event
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cnt_reg <= `AOD_HOLD_ZERO;
      overrange_out <= 1'b0;
      event_pulse <= 1'b0;
    end
    else if (!detect_enable)
    begin
      cnt_reg <= `AOD_HOLD_ZERO;
      overrange_out <= 1'b0;
      event_pulse <= 1'b0;
    end
    else if (hit)
    begin
      cnt_reg <= hold_len - `AOD_HOLD_ONE;
      overrange_out <= 1'b1;
      event_pulse <= 1'b1;
    end
    else
    begin
      event_pulse <= 1'b0;
      if (cnt_reg != `AOD_HOLD_ZERO)
      begin
        cnt_reg <= cnt_reg - `AOD_HOLD_ONE;
      end
      else
      begin
        overrange_out <= 1'b0;
      end
    end
  end

endmodule // aod_chan

// *** hw/aod_cal.v ***
`timescale 1ns/1ps
`include "aod_map.vh"

module aod_cal #(
  parameter CORES = 6,
  parameter [15:0] CAL_CYCLES = `AOD_CAL_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // requests
  input wire fg_start,
  input wire bg_enable,
  // state
  output reg [2:0] cal_core,
  output wire cal_busy,
  output wire fg_active,
  output reg fg_done
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_FG = 3'b010;
  localparam [2:0] ST_BG = 3'b100;
  localparam integer LAST_CORE_I = CORES - 1;
  localparam [2:0] LAST_CORE = LAST_CORE_I[2:0];

  reg [2:0] state_reg;
  reg [15:0] cnt_reg;
  wire slot_end;

  assign slot_end = (cnt_reg == `AOD_CAL_CNT_ZERO);
  assign fg_active = state_reg[1];
  assign cal_busy = ~state_reg[0];

  // core rotation: one core at a time is offline for calibration
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_reg <= ST_IDLE;
      cnt_reg <= `AOD_CAL_CNT_ZERO;
      cal_core <= LAST_CORE;
      fg_done <= 1'b0;
    end
    else
    begin
      fg_done <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          cal_core <= LAST_CORE;
          if (fg_start)
          begin
            state_reg <= ST_FG;
            cal_core <= `AOD_CORE_ZERO;
            cnt_reg <= CAL_CYCLES - `AOD_CAL_CNT_ONE;
          end
          else if (bg_enable)
          begin
            state_reg <= ST_BG;
            cal_core <= LAST_CORE;
            cnt_reg <= CAL_CYCLES - `AOD_CAL_CNT_ONE;
          end
        end
        ST_FG:
        begin
          if (!slot_end)
          begin
            cnt_reg <= cnt_reg - `AOD_CAL_CNT_ONE;
          end
          else if (cal_core == LAST_CORE)
          begin
            state_reg <= ST_IDLE;
            fg_done <= 1'b1;
          end
          else
          begin
            cal_core <= cal_core + `AOD_CORE_ONE;
            cnt_reg <= CAL_CYCLES - `AOD_CAL_CNT_ONE;
          end
        end
        ST_BG:
        begin
          if (!bg_enable)
          begin
            state_reg <= ST_IDLE;
            cal_core <= LAST_CORE;
          end
          else if (!slot_end)
          begin
            cnt_reg <= cnt_reg - `AOD_CAL_CNT_ONE;
          end
          else
          begin
            cal_core <= (cal_core == LAST_CORE) ? `AOD_CORE_ZERO :
                        cal_core + `AOD_CORE_ONE;
            cnt_reg <= CAL_CYCLES - `AOD_CAL_CNT_ONE;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // aod_cal

// *** hw/aod_top.v ***
// How it works
// - one sample captured per converter clock edge
// - samples are 12-bit two's complement values
// - magnitude is 11 bits, minimum code saturates
// - compare upper 8 magnitude bits to threshold
// - one threshold shared by all channels
// - detection works only while enable is set
// - flag set when magnitude bits reach threshold
// - each channel drives its own overrange output
// - output holds 8 to 1024 cycles, restarts
// - spare cores swapped in during calibration
// - foreground halts sampling, background keeps sampling
`timescale 1ns/1ps
`include "aod_map.vh"

module aod_top #(
  parameter NUM_CH = 4,
  parameter CORES = 6,
  parameter SW = 12,
  parameter [15:0] CAL_CYCLES = `AOD_CAL_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // converter core samples, core k in bits [k*12 +: 12]
  input wire [CORES*SW-1:0] core_sample,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [7:0] reg_rdata,
  // interrupt
  output wire irq,
  // samples to downstream logic, channel i in bits [i*12 +: 12]
  output reg [4*SW-1:0] chan_sample,
  output reg chan_sample_valid,
  // overrange outputs
  output wire overrange_out_a,
  output wire overrange_out_b,
  output wire overrange_out_c,
  output wire overrange_out_d
);

  reg [7:0] ctrl_reg;
  reg [7:0] thresh_reg;
  reg [7:0] mask_reg;
  reg [7:0] status_reg;
  reg [7:0] status_next;
  reg [7:0] rdata_next;
  reg fg_start_reg;
  wire [2:0] cal_core;
  wire cal_busy;
  wire fg_active;
  wire fg_done;
  wire [3:0] ovr_out;
  wire [3:0] ovr_event;
  wire [4*SW-1:0] chan_in;
  wire detect_enable;
  wire [2:0] hold_select;
  wire [7:0] status_set;
  wire [7:0] status_clr;
  wire wr_ctrl;

  assign detect_enable = ctrl_reg[`AOD_CTRL_EN];
  assign hold_select = ctrl_reg[`AOD_CTRL_HOLD_HI:`AOD_CTRL_HOLD_LO];
  assign wr_ctrl = reg_write && (reg_addr == `AOD_ADDR_CTRL);

  // control, threshold and mask registers
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_reg <= `AOD_CTRL_RST;
      thresh_reg <= `AOD_THRESH_RST;
      mask_reg <= `AOD_MASK_RST;
      fg_start_reg <= 1'b0;
    end
    else
    begin
      fg_start_reg <= wr_ctrl && reg_wdata[`AOD_CTRL_FGSTART];
      if (wr_ctrl)
      begin
        ctrl_reg <= {3'h0, reg_wdata[`AOD_CTRL_BGCAL:0]};
      end
      if (reg_write && (reg_addr == `AOD_ADDR_THRESH))
      begin
        thresh_reg <= reg_wdata;
      end
      if (reg_write && (reg_addr == `AOD_ADDR_MASK))
      begin
        mask_reg <= {3'h0, reg_wdata[`AOD_STAT_FGDONE:0]};
      end
    end
  end

  // sticky status: hardware set wins over read clear
  assign status_set = {3'h0, fg_done, ovr_event};
  assign status_clr = (reg_read && (reg_addr == `AOD_ADDR_STATUS)) ? status_reg : 8'h00;

  always @*
  begin
    status_next = (status_reg & ~status_clr) | status_set;
  end

  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      status_reg <= `AOD_STATUS_RST;
    end
    else
    begin
      status_reg <= status_next;
    end
  end

  assign irq = |(status_reg & mask_reg);

  // read mux, unmapped addresses read zero
  always @*
  begin
    rdata_next = 8'h00;
    case (reg_addr)
      `AOD_ADDR_CTRL: rdata_next = ctrl_reg;
      `AOD_ADDR_THRESH: rdata_next = thresh_reg;
      `AOD_ADDR_STATUS: rdata_next = status_reg;
      `AOD_ADDR_MASK: rdata_next = mask_reg;
      `AOD_ADDR_STATE: rdata_next = {cal_core, cal_busy, ovr_out};
      default: rdata_next = 8'h00;
    endcase
  end

  // read data stand one cycle after the strobe only
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata <= `AOD_RDATA_RST;
    end
    else if (reg_read)
    begin
      reg_rdata <= rdata_next;
    end
    else
    begin
      reg_rdata <= 8'h00;
    end
  end

  // calibration sequencer and core swapping
  aod_cal #(
    .CORES(CORES),
    .CAL_CYCLES(CAL_CYCLES)
  ) u_cal (
    .clk(clk),
    .reset(reset),
    .fg_start(fg_start_reg),
    .bg_enable(ctrl_reg[`AOD_CTRL_BGCAL]),
    .cal_core(cal_core),
    .cal_busy(cal_busy),
    .fg_active(fg_active),
    .fg_done(fg_done)
  );

  // channel lanes: core routing, detection and hold
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1)
    begin : g_ch
      if (i < NUM_CH)
      begin : g_on
        // cores at or above the calibrating one shift up by one
        assign chan_in[i*SW +: SW] = (i >= cal_core) ?
          core_sample[(i+1)*SW +: SW] : core_sample[i*SW +: SW];

        aod_chan #(
          .SW(SW),
          .MW(SW-1),
          .CW(11)
        ) u_chan (
          .clk(clk),
          .reset(reset),
          .sample(chan_sample[i*SW +: SW]),
          .sample_valid(chan_sample_valid),
          .detect_enable(detect_enable),
          .threshold(thresh_reg),
          .hold_select(hold_select),
          .overrange_out(ovr_out[i]),
          .event_pulse(ovr_event[i])
        );
      end
      else
      begin : g_off
        assign chan_in[i*SW +: SW] = {SW{1'b0}};
        assign ovr_out[i] = 1'b0;
        assign ovr_event[i] = 1'b0;
      end
    end
  endgenerate

  // sample capture every edge, halted by foreground calibration
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      chan_sample <= {4*SW{1'b0}};
      chan_sample_valid <= 1'b0;
    end
    else if (fg_active)
    begin
      chan_sample_valid <= 1'b0;
    end
    else
    begin
      chan_sample <= chan_in;
      chan_sample_valid <= 1'b1;
    end
  end

  // dedicated output per channel
  assign overrange_out_a = ovr_out[0];
  assign overrange_out_b = ovr_out[1];
  assign overrange_out_c = ovr_out[2];
  assign overrange_out_d = ovr_out[3];

endmodule // aod_top

// *** verif/aod_assertions.sv ***
`timescale 1ns/1ps
module aod_assertions #(
  parameter SW = 12
) (
  // clock and reset
  input wire clk,
  input wire reset,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata,
  input wire irq,
  // channel side
  input wire [4*SW-1:0] chan_sample,
  input wire chan_sample_valid,
  input wire overrange_out_a,
  input wire overrange_out_b,
  input wire overrange_out_c,
  input wire overrange_out_d
);
  reg en_s;
  reg [2:0] sel_s;
  reg [7:0] thr_s;
  reg [4:0] mask_s;
  reg [10:0] mc [0:3];
  wire [3:0] hitv;
  wire [3:0] mcnz;
  wire [3:0] outs;
  integer i;
  genvar g;
  // upper magnitude bits, lowest code saturates
  function [7:0] mag8(input [11:0] s);
    reg [11:0] m;
    begin
      m = s[11] ? (~s + 12'h001) : s;
      mag8 = (s == 12'h800) ? 8'hFF : m[10:3];
    end
  endfunction
  assign outs = {overrange_out_d, overrange_out_c, overrange_out_b, overrange_out_a};
  // per channel compare and pending hold
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_ch
      assign hitv[g] = mag8(chan_sample[g*SW +: 12]) >= thr_s;
      assign mcnz[g] = mc[g] != 11'h000;
    end
  endgenerate
  // register shadows and hold countdown
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      en_s <= 1'b0;
      sel_s <= 3'h0;
      thr_s <= 8'hE4;
      mask_s <= 5'h00;
      for (i = 0; i < 4; i = i + 1)
        mc[i] <= 11'h000;
    end
    else
    begin
      for (i = 0; i < 4; i = i + 1)
        mc[i] <= !en_s ? 11'h000 : (chan_sample_valid && hitv[i]) ? (11'h008 << sel_s) :
          mcnz[i] ? mc[i] - 11'h001 : 11'h000;
      if (reg_write && reg_addr == 8'h00)
      begin
        en_s <= reg_wdata[0];
        sel_s <= reg_wdata[3:1];
      end
      if (reg_write && reg_addr == 8'h04)
        thr_s <= reg_wdata;
      if (reg_write && reg_addr == 8'h0C)
        mask_s <= reg_wdata[4:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_hit;
    en_s && chan_sample_valid && hitv != 4'h0;
  endsequence
  sequence s_new_a;
    en_s && chan_sample_valid && hitv[0] && !overrange_out_a && mask_s[0];
  endsequence
  property p_hit;
    s_hit |=> (outs & $past(hitv)) == $past(hitv);
  endproperty
  property p_len;
    en_s && $past(en_s) |-> outs == mcnz;
  endproperty
  property p_off;
    !en_s && !$past(en_s) |-> outs == 4'h0;
  endproperty
  property p_rd_idle;
    !$past(reg_read) |-> reg_rdata == 8'h00;
  endproperty
  property p_unmapped;
    $past(reg_read && (reg_addr > 8'h10 || reg_addr[1:0] != 2'h0)) |-> reg_rdata == 8'h00;
  endproperty
  property p_thr;
    $past(reg_read && reg_addr == 8'h04) |-> reg_rdata == thr_s;
  endproperty
  property p_irq_off;
    mask_s == 5'h00 |-> !irq;
  endproperty
  property p_irq_ev;
    s_new_a ##1 (!reg_read && mask_s[0]) [*2] ##1 mask_s[0] |-> irq;
  endproperty
  a_hit: assert property (p_hit) else $error("flag missed a hit");
  a_len: assert property (p_len) else $error("flag length wrong");
  a_off: assert property (p_off) else $error("flag while disabled");
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_thr: assert property (p_thr) else $error("threshold readback wrong");
  a_irq_off: assert property (p_irq_off) else $error("irq while masked");
  a_irq_ev: assert property (p_irq_ev) else $error("event did not raise irq");
endmodule // aod_assertions

bind aod_top aod_assertions #(.SW(SW)) u_chk (.clk(clk), .reset(reset), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .irq(irq), .chan_sample(chan_sample), .chan_sample_valid(chan_sample_valid),
  .overrange_out_a(overrange_out_a), .overrange_out_b(overrange_out_b),
  .overrange_out_c(overrange_out_c), .overrange_out_d(overrange_out_d));

// *** verif/aod_gain_mgr.sv ***
`timescale 1ns/1ps
module aod_gain_mgr (
  // clock and reset
  input wire clk,
  input wire reset,
  // detector side
  input wire [3:0] overrange_vec,
  input wire [47:0] chan_sample,
  input wire chan_sample_valid,
  // gain request
  output reg gain_cut
);
  reg [4:0] quiet_reg;
  wire calm;
  // all channels below half scale
  assign calm = chan_sample_valid && (chan_sample[47] == chan_sample[46]) &&
    (chan_sample[35] == chan_sample[34]) && (chan_sample[23] == chan_sample[22]) &&
    (chan_sample[11] == chan_sample[10]);
  // cut gain on a flag, restore after a calm run
  always @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      gain_cut <= 1'b0;
      quiet_reg <= 5'h00;
    end
    else if (overrange_vec != 4'h0)
    begin
      gain_cut <= 1'b1;
      quiet_reg <= 5'h00;
    end
    else if (calm)
    begin
      quiet_reg <= quiet_reg + 5'h01;
      if (quiet_reg == 5'h1F)
        gain_cut <= 1'b0;
    end
  end
endmodule // aod_gain_mgr

// *** verif/tb_adc_overrange_detector.sv ***
`timescale 1ns/1ps
module tb_adc_overrange_detector;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg [71:0] core_sample = 72'h0;
  reg [7:0] reg_addr = 8'h00;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_write = 1'b0;
  reg reg_read = 1'b0;
  wire [7:0] reg_rdata;
  wire irq;
  wire [47:0] chan_sample;
  wire chan_sample_valid;
  wire [3:0] ovr;
  wire gain_cut;
  reg [7:0] rv;
  reg [11:0] tv [0:6];
  integer num_errors = 0;
  integer samples_checked = 0;
  integer seed = 32'h450a3fca;
  integer cyc = 0;
  integer t, c, n;
  integer hc [0:3];
  aod_top #(.CAL_CYCLES(16'h0002)) dut_u (.clk(clk), .reset(reset), .core_sample(core_sample),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq(irq), .chan_sample(chan_sample),
    .chan_sample_valid(chan_sample_valid), .overrange_out_a(ovr[0]), .overrange_out_b(ovr[1]),
    .overrange_out_c(ovr[2]), .overrange_out_d(ovr[3]));
  aod_gain_mgr u_gain (.clk(clk), .reset(reset), .overrange_vec(ovr), .chan_sample(chan_sample),
    .chan_sample_valid(chan_sample_valid), .gain_cut(gain_cut));
  // free running clock
  initial
  begin
    forever #25 clk = ~clk;
  end
  // hang guard
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 9000)
    begin
      num_errors = num_errors + 1;
      complete_run;
    end
  end
  task complete_run;
    begin
      $display("checked %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [47:0] seen, input [47:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
        num_errors = num_errors + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task done(input integer k);
    begin
      $display("test %0d finished", k);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge clk);
      reg_write <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge clk);
      reg_read <= 1'b0;
      @(negedge clk);
      rv = reg_rdata;
    end
  endtask
  // one sample on one channel, returns once the flag has settled
  task hit(input [11:0] s, input integer ch);
    begin
      @(posedge clk);
      core_sample <= {60'h0, s} << (12 * ch);
      @(posedge clk);
      core_sample <= 72'h0;
      @(posedge clk);
      @(negedge clk);
    end
  endtask
  // expected flag from the signed sample value
  function exph(input [11:0] s, input [7:0] th);
    integer m;
    begin
      m = s[11] ? 4096 - s : s;
      if (m > 2047)
        m = 2047;
      exph = (m / 8) >= th;
    end
  endfunction
  // main sequence
  initial
  begin
    tv[0] = 12'h7FF;
    tv[1] = 12'h7F0;
    tv[2] = 12'h000;
    tv[3] = 12'h810;
    tv[4] = 12'h800;
    tv[5] = 12'h7EF;
    tv[6] = 12'hFFF;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    rd(8'h00);
    chk(rv, 8'h00);
    rd(8'h04);
    chk(rv, 8'hE4);
    rd(8'h14);
    chk(rv, 8'h00);
    done(1);
    wr(8'h00, 8'h01);
    wr(8'h04, 8'hFE);
    for (c = 0; c < 4; c = c + 1)
      for (t = 0; t < 7; t = t + 1)
      begin
        hit(tv[t], c);
        chk(ovr, {3'h0, exph(tv[t], 8'hFE)} << c);
        repeat (10) @(posedge clk);
      end
    done(2);
    for (t = 0; t < 8; t = t + 1)
    begin
      wr(8'h00, 8'(t * 2 + 1));
      hit(12'h800, 0);
      n = ovr[0];
      repeat ((8 << t) + 4) @(negedge clk) if (ovr[0] === 1'b1) n = n + 1;
      chk(n, 8 << t);
    end
    done(3);
    wr(8'h00, 8'h07);
    hit(12'h7FF, 1);
    wr(8'h00, 8'h00);
    repeat (2) @(negedge clk);
    chk(ovr, 4'h0);
    hit(12'h7FF, 2);
    chk(ovr, 4'h0);
    wr(8'h00, 8'h01);
    repeat (3) @(negedge clk);
    chk(ovr, 4'h0);
    repeat (40) @(negedge clk);
    chk(gain_cut, 1'b0);
    done(4);
    rd(8'h08);
    wr(8'h0C, 8'h01);
    hit(12'h7FF, 0);
    @(negedge clk);
    chk(irq, 1'b1);
    chk(gain_cut, 1'b1);
    rd(8'h08);
    chk(rv, 8'h01);
    chk(irq, 1'b0);
    hit(12'h7FF, 1);
    @(negedge clk);
    chk(irq, 1'b0);
    rd(8'h08);
    chk(rv, 8'h02);
    done(5);
    wr(8'h00, 8'h21);
    n = 0;
    repeat (40) @(negedge clk) if (chan_sample_valid !== 1'b1) n = n + 1;
    chk(n != 0, 1'b1);
    rd(8'h08);
    chk(rv[4], 1'b1);
    done(6);
    @(posedge clk);
    core_sample <= {12'h505, 12'h504, 12'h503, 12'h502, 12'h501, 12'h500};
    wr(8'h00, 8'h10);
    n = 0;
    c = 0;
    // every channel shows its own core or the next one up
    repeat (40)
    begin
      @(negedge clk);
      for (t = 0; t < 4; t = t + 1)
        if (chan_sample[t*12 +: 12] !== 12'h500 + t && chan_sample[t*12 +: 12] !== 12'h501 + t)
          n = n + 1;
      if (!chan_sample_valid)
        n = n + 1;
      if (chan_sample[11:0] === 12'h501)
        c = c + 1;
    end
    chk(n, 0);
    chk(c != 0, 1'b1);
    rd(8'h10);
    chk(rv[4], 1'b1);
    done(7);
    rv = 8'($random(seed));
    wr(8'h04, rv);
    wr(8'h00, 8'h03);
    for (c = 0; c < 4; c = c + 1)
      hc[c] = 0;
    // bench model of the hold countdown, code 1 gives 16 cycles
    repeat (400)
    begin
      @(negedge clk);
      for (c = 0; c < 4; c = c + 1)
      begin
        chk(ovr[c], hc[c] != 0);
        hc[c] = exph(chan_sample[c*12 +: 12], rv) ? 16 : (hc[c] != 0) ? hc[c] - 1 : 0;
      end
      @(posedge clk);
      core_sample <= 72'({$random(seed), $random(seed), $random(seed)});
    end
    @(posedge clk);
    core_sample <= 72'h0;
    done(8);
    complete_run;
  end
endmodule // tb_adc_overrange_detector
